// File: core/pld_consts.vh
`ifndef PLD_CONSTS_VH
`define PLD_CONSTS_VH

// ****************************************
// register word indices (byte address = 4 * index)
// ****************************************
`define PLD_IDX_LDC 6'h07
`define PLD_IDX_AEN 6'h08
`define PLD_IDX_STAT 6'h10
`define PLD_IDX_IRQ_STAT 6'h11
`define PLD_IDX_IRQ_EN 6'h12
`define PLD_IDX_IRQ_CLR 6'h13

// ****************************************
// reset values and write masks
// ****************************************
`define PLD_LDC_RST 24'h00014D
`define PLD_LDC_MASK 24'h003FCF
`define PLD_AEN_RST 24'hC1BEFF
`define PLD_IRQ_RST 3'h0

// ****************************************
// lock detect config fields
// ****************************************
`define PLD_LDC_CNT_LSB 0
`define PLD_LDC_EN_BIT 3
`define PLD_LDC_DIG_BIT 6
`define PLD_LDC_DUR_LSB 7
`define PLD_LDC_SPD_LSB 10
`define PLD_LDC_TEST_BIT 12
`define PLD_LDC_RELOCK_BIT 13

// ****************************************
// block enable fields
// ****************************************
`define PLD_AEN_BIAS_BIT 0
`define PLD_AEN_CP_BIT 1
`define PLD_AEN_PD_BIT 2
`define PLD_AEN_REFBUF_BIT 3
`define PLD_AEN_OSCBUF_BIT 4
`define PLD_AEN_PAD_BIT 5
`define PLD_AEN_HFREF_BIT 21

// ****************************************
// interrupt bits
// ****************************************
`define PLD_IRQ_GAIN_BIT 0
`define PLD_IRQ_LOST_BIT 1
`define PLD_IRQ_RELOCK_BIT 2

// ****************************************
// timing
// ****************************************
`define PLD_THR_0 17'h00005
`define PLD_THR_1 17'h00020
`define PLD_THR_2 17'h00060
`define PLD_THR_3 17'h00100
`define PLD_THR_4 17'h00200
`define PLD_THR_5 17'h00800
`define PLD_THR_6 17'h02000
`define PLD_THR_7 17'h0FFFF
`define PLD_CLK_MHZ 50
`define PLD_ANA_WIN_NS 10
`define PLD_ANA_WIN_RAW ((`PLD_ANA_WIN_NS * `PLD_CLK_MHZ) / 1000)
`define PLD_ANA_WIN_CYC ((`PLD_ANA_WIN_RAW < 1) ? 1 : `PLD_ANA_WIN_RAW)

`endif

// File: core/pld_lock_enables.v
// Operation
// - lock after coded count of in-window edges
// - detection runs only while enable bit set
// - bit six picks digital timer or one-shot
// - duration code sets 1 to 128 timer ticks
// - two-bit code sets timer clock rate
// - test bit keeps timer clock running
// - one relock attempt after failure, no retry
// - pad enable zero disables shared pin
// - pad and pin-function set: always drive
// - otherwise driver off on unmatched address
// - five bits enable analog blocks, reset one
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pld_consts.vh"

module pld_lock_enables (
  input wire hclk, // bus and logic clock
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [7:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  output wire hreadyout, // slave ready
  output wire hresp, // response, always okay
  output wire [31:0] hrdata, // read data
  input wire ref_edge_in, // reference path clock pin
  input wire vco_div_in, // divided oscillator pin
  input wire pin_function_gpo, // bit 7 of pin function register
  input wire serial_addr_match, // serial bus carries our chip address
  input wire serial_readback_data, // serial readback bit
  input wire gpo_data, // general-purpose output bit
  output wire lock_serial_out_pin_o, // shared pad output value
  output wire lock_serial_out_pin_oe, // shared pad output enable
  output wire serial_readback_driver, // readback driver active
  output wire lock_detect, // lock indication
  output wire relock_request, // one-cycle relock pulse
  output wire bias_enable, // bias reference enable
  output wire charge_pump_enable, // charge pump enable
  output wire phase_detector_enable, // phase detector enable
  output wire ref_buffer_enable, // reference buffer enable
  output wire osc_buffer_enable, // oscillator rf buffer enable
  output wire high_freq_ref, // high-frequency reference handling
  output wire irq // level interrupt
);

  // ****************************************
  // declarations
  // ****************************************
  reg [23:0] ldc_r;
  reg [23:0] ldc_nxt;
  reg [23:0] aen_r;
  reg [23:0] aen_nxt;
  reg [2:0] irq_en_r;
  reg [2:0] irq_en_nxt;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_stat_nxt;
  reg [2:0] irq_clr;
  reg dph_r;
  reg dph_wr_r;
  reg [5:0] dph_idx_r;
  reg [31:0] hrdata_r;
  reg [31:0] rd_nxt;
  reg ref_s1_r;
  reg ref_s2_r;
  reg ref_s3_r;
  reg vco_s1_r;
  reg vco_s2_r;
  reg vco_s3_r;
  reg [16:0] cnt_r;
  reg [16:0] cnt_nxt;
  reg lock_r;
  reg lock_nxt;
  reg lost_evt;
  reg gain_evt;
  reg relock_used_r;
  reg relock_r;
  reg relock_nxt;
  reg pad_o_r;
  reg pad_oe_r;
  reg rb_drv_r;
  wire aph;
  wire ref_rise;
  wire vco_rise;
  wire win_open;
  wire ld_en;
  wire [16:0] thr;
  wire wr_ldc;

  // ****************************************
  // edge count threshold
  // ****************************************
  function [16:0] pld_thr;
    input [2:0] code;
    begin
      case (code)
        3'h0: pld_thr = `PLD_THR_0;
        3'h1: pld_thr = `PLD_THR_1;
        3'h2: pld_thr = `PLD_THR_2;
        3'h3: pld_thr = `PLD_THR_3;
        3'h4: pld_thr = `PLD_THR_4;
        3'h5: pld_thr = `PLD_THR_5;
        3'h6: pld_thr = `PLD_THR_6;
        default: pld_thr = `PLD_THR_7;
      endcase
    end
  endfunction

  assign thr = pld_thr(ldc_r[`PLD_LDC_CNT_LSB+2:`PLD_LDC_CNT_LSB]);
  assign ld_en = ldc_r[`PLD_LDC_EN_BIT];

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  assign aph = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign wr_ldc = dph_r & dph_wr_r & (dph_idx_r == `PLD_IDX_LDC);

  always @* begin
    ldc_nxt = ldc_r;
    aen_nxt = aen_r;
    irq_en_nxt = irq_en_r;
    irq_clr = 3'h0;
    if (dph_r && dph_wr_r) begin
      case (dph_idx_r)
        `PLD_IDX_LDC: ldc_nxt = hwdata[23:0] & `PLD_LDC_MASK;
        `PLD_IDX_AEN: aen_nxt = hwdata[23:0];
        `PLD_IDX_IRQ_EN: irq_en_nxt = hwdata[2:0];
        `PLD_IDX_IRQ_CLR: irq_clr = hwdata[2:0];
        default: ldc_nxt = ldc_r;
      endcase
    end
  end

  // read mux on next values so a write right before a read is seen
  always @* begin
    rd_nxt = 32'h00000000;
    case (haddr[7:2])
      `PLD_IDX_LDC: rd_nxt = {8'h00, ldc_nxt};
      `PLD_IDX_AEN: rd_nxt = {8'h00, aen_nxt};
      `PLD_IDX_STAT: rd_nxt = {7'h00, cnt_nxt, 5'h00, relock_used_r, win_open, lock_nxt};
      `PLD_IDX_IRQ_STAT: rd_nxt = {29'h00000000, irq_stat_nxt};
      `PLD_IDX_IRQ_EN: rd_nxt = {29'h00000000, irq_en_nxt};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r <= 1'b0;
      dph_wr_r <= 1'b0;
      dph_idx_r <= 6'h00;
      hrdata_r <= 32'h00000000;
      ldc_r <= `PLD_LDC_RST;
      aen_r <= `PLD_AEN_RST;
      irq_en_r <= `PLD_IRQ_RST;
      irq_stat_r <= `PLD_IRQ_RST;
    end else begin
      dph_r <= aph;
      dph_wr_r <= hwrite;
      dph_idx_r <= haddr[7:2];
      if (aph && !hwrite) begin
        hrdata_r <= rd_nxt;
      end
      ldc_r <= ldc_nxt;
      aen_r <= aen_nxt;
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // ****************************************
  // interrupts: set wins over clear
  // ****************************************
  always @* begin
    irq_stat_nxt = irq_stat_r & ~irq_clr;
    irq_stat_nxt[`PLD_IRQ_GAIN_BIT] = irq_stat_nxt[`PLD_IRQ_GAIN_BIT] | gain_evt;
    irq_stat_nxt[`PLD_IRQ_LOST_BIT] = irq_stat_nxt[`PLD_IRQ_LOST_BIT] | lost_evt;
    irq_stat_nxt[`PLD_IRQ_RELOCK_BIT] = irq_stat_nxt[`PLD_IRQ_RELOCK_BIT] | relock_nxt;
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      vco_s1_r <= 1'b0;
      vco_s2_r <= 1'b0;
      vco_s3_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_edge_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      vco_s1_r <= vco_div_in;
      vco_s2_r <= vco_s1_r;
      vco_s3_r <= vco_s2_r;
    end
  end

  // both pins must toggle slower than hclk / 2 or edges are missed
  assign ref_rise = ref_s2_r & ~ref_s3_r;
  assign vco_rise = vco_s2_r & ~vco_s3_r;

  // ****************************************
  // detection window
  // ****************************************
  pld_win_timer #(
    .ANA_CYC(`PLD_ANA_WIN_CYC)
  ) u_win (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(ref_rise & ld_en),
    .digital(ldc_r[`PLD_LDC_DIG_BIT]),
    .dur(ldc_r[`PLD_LDC_DUR_LSB+2:`PLD_LDC_DUR_LSB]),
    .speed(ldc_r[`PLD_LDC_SPD_LSB+1:`PLD_LDC_SPD_LSB]),
    .test_mode(ldc_r[`PLD_LDC_TEST_BIT]),
    .win_open(win_open)
  );

  // ****************************************
  // lock counting
  // ****************************************
  always @* begin
    cnt_nxt = cnt_r;
    lock_nxt = lock_r;
    lost_evt = 1'b0;
    if (!ld_en) begin
      cnt_nxt = 17'h00000;
      lock_nxt = 1'b0;
    end else if (vco_rise) begin
      if (win_open) begin
        if (cnt_r < thr) begin
          cnt_nxt = cnt_r + 17'h00001;
        end
        if (cnt_nxt >= thr) begin
          lock_nxt = 1'b1;
        end
      end else begin
        cnt_nxt = 17'h00000;
        lock_nxt = 1'b0;
        lost_evt = lock_r;
      end
    end
    gain_evt = lock_nxt & ~lock_r;
    // a config rewrite re-arms the single attempt
    relock_nxt = lost_evt & ldc_r[`PLD_LDC_RELOCK_BIT] & ~relock_used_r & ~wr_ldc;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 17'h00000;
      lock_r <= 1'b0;
      relock_r <= 1'b0;
      relock_used_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      lock_r <= lock_nxt;
      relock_r <= relock_nxt;
      if (wr_ldc) begin
        relock_used_r <= 1'b0;
      end else if (relock_nxt) begin
        relock_used_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // shared output pad
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_o_r <= 1'b0;
      pad_oe_r <= 1'b0;
      rb_drv_r <= 1'b0;
    end else begin
      pad_o_r <= pin_function_gpo ? gpo_data : serial_readback_data;
      if (!aen_r[`PLD_AEN_PAD_BIT]) begin
        pad_oe_r <= 1'b0;
        rb_drv_r <= 1'b0;
      end else if (pin_function_gpo) begin
        pad_oe_r <= 1'b1;
        rb_drv_r <= 1'b0;
      end else begin
        pad_oe_r <= serial_addr_match;
        rb_drv_r <= serial_addr_match;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign lock_serial_out_pin_o = pad_o_r;
  assign lock_serial_out_pin_oe = pad_oe_r;
  assign serial_readback_driver = rb_drv_r;
  assign lock_detect = lock_r;
  assign relock_request = relock_r;
  assign bias_enable = aen_r[`PLD_AEN_BIAS_BIT];
  assign charge_pump_enable = aen_r[`PLD_AEN_CP_BIT];
  assign phase_detector_enable = aen_r[`PLD_AEN_PD_BIT];
  assign ref_buffer_enable = aen_r[`PLD_AEN_REFBUF_BIT];
  assign osc_buffer_enable = aen_r[`PLD_AEN_OSCBUF_BIT];
  assign high_freq_ref = aen_r[`PLD_AEN_HFREF_BIT];

endmodule // pld_lock_enables

// File: core/pld_win_timer.v
`timescale 1ns/1ps
`include "pld_consts.vh"

module pld_win_timer #(
  parameter ANA_CYC = `PLD_ANA_WIN_CYC
) (
  input wire hclk, // system clock
  input wire hresetn, // async reset, active low
  input wire start, // open a window, one-cycle pulse
  input wire digital, // 1 digital timer, 0 one-shot stand-in
  input wire [2:0] dur, // digital duration code
  input wire [1:0] speed, // timer clock rate code, 0 fastest
  input wire test_mode, // keep timer clock running
  output wire win_open // window currently open
);

  localparam integer ANA_M1_I = ANA_CYC - 1;
  localparam [7:0] ANA_M1 = ANA_M1_I[7:0];

  reg open_r;
  reg [3:0] pres_r;
  reg [7:0] ht_r;
  reg [7:0] ana_r;
  reg [7:0] len_m1;
  reg [3:0] per_m1;
  reg tick;

  // ****************************************
  // half-tick length and prescaler period
  // ****************************************
  always @* begin
    len_m1 = (8'h01 << dur) - 8'h01;
    per_m1 = (4'h1 << speed) - 4'h1;
    tick = (pres_r == per_m1);
  end

  // ****************************************
  // window timing
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_r <= 1'b0;
      pres_r <= 4'h0;
      ht_r <= 8'h00;
      ana_r <= 8'h00;
    end else begin
      // free-running prescaler in test mode: window edges lose phase alignment
      if (start && !test_mode) begin
        pres_r <= 4'h0;
      end else if (open_r || test_mode) begin
        pres_r <= tick ? 4'h0 : pres_r + 4'h1;
      end
      if (start) begin
        open_r <= 1'b1;
        ht_r <= 8'h00;
        ana_r <= 8'h00;
      end else if (open_r) begin
        if (digital) begin
          if (tick) begin
            if (ht_r == len_m1) begin
              open_r <= 1'b0;
            end else begin
              ht_r <= ht_r + 8'h01;
            end
          end
        end else begin
          if (ana_r == ANA_M1) begin
            open_r <= 1'b0;
          end else begin
            ana_r <= ana_r + 8'h01;
          end
        end
      end
    end
  end

  assign win_open = open_r;

endmodule // pld_win_timer

// File: dv/pld_lock_enables_bench.sv
`timescale 1ns/1ps
`include "pld_consts.vh"
module pld_lock_enables_bench;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'b00;
  reg [31:0] hwdata = 32'h0;
  reg gpo = 1'b0, match = 1'b0, sdata = 1'b0, gdata = 1'b0, run = 1'b0;
  reg [3:0] lag = 4'h1;
  wire hreadyout, hresp, ref_in, vco_in, pad_o, pad_oe, drv, lock, relock, irq;
  wire [31:0] hrdata;
  wire [5:0] en;
  int miscompares = 0, n_compared = 0, cyc = 0, rk = 0, r0;
  int nt[8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
  logic [23:0] tc[8] = '{24'h008, 24'h008, 24'h0C8, 24'h8C8, 24'h1148, 24'h040, 24'h048, 24'h048};
  logic [3:0] lg[8] = '{4'h1, 4'h3, 4'h6, 4'h6, 4'h2, 4'h1, 4'h1, 4'h4};
  logic [31:0] q, v;
  always #10 hclk = ~hclk;
  pld_lock_enables dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_edge_in(ref_in),
    .vco_div_in(vco_in), .pin_function_gpo(gpo), .serial_addr_match(match),
    .serial_readback_data(sdata), .gpo_data(gdata), .lock_serial_out_pin_o(pad_o),
    .lock_serial_out_pin_oe(pad_oe), .serial_readback_driver(drv), .lock_detect(lock),
    .relock_request(relock), .bias_enable(en[0]), .charge_pump_enable(en[1]),
    .phase_detector_enable(en[2]), .ref_buffer_enable(en[3]), .osc_buffer_enable(en[4]),
    .high_freq_ref(en[5]), .irq(irq));
  pld_pll_model u_pll (.hclk(hclk), .run(run), .lag(lag), .ref_edge_in(ref_in),
    .vco_div_in(vco_in));
  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (relock === 1'b1) rk <= rk + 1;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {ix, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input string nm, input logic [5:0] ix, input logic [31:0] e);
    bus(1'b0, ix, 32'h0);
    chk(nm, e, q);
  endtask
  // expected consecutive in-window count after n oscillator periods
  function automatic int xc(input logic [23:0] c, input int l, input int n);
    int w;
    w = c[6] ? (1 << c[9:7]) << c[11:10] : 1;
    if (!c[3] || l < 1 || l > w) return 0;
    return n < nt[c[2:0]] ? n : nt[c[2:0]];
  endfunction
  task automatic tl(input logic [23:0] c, input logic [3:0] l, input int n, input bit wr);
    int x;
    x = xc(c, l, n);
    if (wr) begin
      bus(1'b1, 6'h07, 32'h0);
      bus(1'b1, 6'h07, {8'h00, c});
    end
    run <= 1'b0;
    repeat (3) @(posedge hclk);
    lag <= l;
    run <= 1'b1;
    // stop on a period boundary: a clipped last period would put a short pulse on the pins
    repeat (16 * n) @(posedge hclk);
    run <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("lock", x == nt[c[2:0]], lock);
    bus(1'b0, 6'h10, 32'h0);
    chk("count", {7'h0, 17'(x), 7'h0, x == nt[c[2:0]]}, q & 32'h01FFFF01);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    void'($urandom(32'hC916DA28));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ldc", 6'h07, `PLD_LDC_RST);
    rd("aen", 6'h08, `PLD_AEN_RST);
    chk("enables", 32'h1F, en);
    chk("hresp", 32'h0, hresp);
    bus(1'b1, 6'h07, 32'hFFFFFFFF);
    rd("ldc", 6'h07, 32'h3FCF);
    v = $urandom & 32'hFFFFFF;
    bus(1'b1, 6'h08, v);
    rd("aen", 6'h08, v);
    chk("enables", {v[21], v[4:0]}, en);
    bus(1'b1, 6'h20, 32'hFFFF);
    rd("unmapped", 6'h20, 32'h0);
    bus(1'b1, 6'h11, 32'h7);
    rd("irq_stat", 6'h11, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 6'h08, `PLD_AEN_RST ^ {!i[0], 5'h00});
      gpo <= i[1];
      match <= i[2];
      sdata <= 1'($urandom);
      gdata <= 1'($urandom);
      repeat (2) @(posedge hclk);
      chk("pad_oe", i[0] & (i[1] | i[2]), pad_oe);
      chk("driver", i[0] & !i[1] & i[2], drv);
      if (i[0] & (i[1] | i[2])) chk("pad_o", i[1] ? gdata : sdata, pad_o);
    end
    bus(1'b1, 6'h08, `PLD_AEN_RST | 24'h200000);
    for (int i = 0; i < 8; i++) tl(tc[i], lg[i], 6, 1);
    for (int k = 0; k < 5; k++) begin
      v = 32'h48 | k | (($urandom % 3) << 7) | (($urandom % 2) << 10);
      tl(v[23:0], 4'h1, nt[k] - 1, 1);
      tl(v[23:0], 4'h1, nt[k], 1);
    end
    tl(24'h2008, 4'h1, 6, 1);
    bus(1'b1, 6'h13, 32'h7);
    r0 = rk;
    tl(24'h2008, 4'hC, 2, 0);
    chk("relocks", r0 + 1, rk);
    rd("stat", 6'h10, 32'h4);
    rd("irq_stat", 6'h11, 32'h6);
    chk("irq", 0, irq);
    bus(1'b1, 6'h12, 32'h2);
    @(posedge hclk);
    chk("irq", 1, irq);
    rd("irq_en", 6'h12, 32'h2);
    rd("irq_clr", 6'h13, 32'h0);
    bus(1'b1, 6'h13, 32'h2);
    @(posedge hclk);
    chk("irq", 0, irq);
    rd("irq_stat", 6'h11, 32'h4);
    tl(24'h2008, 4'h1, 6, 0);
    tl(24'h2008, 4'hC, 2, 0);
    chk("relocks", r0 + 1, rk);
    summarize();
  end
endmodule // pld_lock_enables_bench

// File: dv/pld_lock_enables_monitor.sv
`timescale 1ns/1ps
module pld_lock_enables_monitor (
  input wire hclk, // clock
  input wire hresetn, // reset, active low
  input wire hsel, // select
  input wire [7:0] haddr, // address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write
  input wire hready, // bus ready
  input wire [31:0] hrdata, // read data
  input wire vco_div_in, // divided oscillator
  input wire pin_function_gpo, // pad function
  input wire serial_addr_match, // address match
  input wire serial_readback_data, // readback bit
  input wire gpo_data, // gpo bit
  input wire lock_serial_out_pin_o, // pad value
  input wire lock_serial_out_pin_oe, // pad enable
  input wire serial_readback_driver, // driver on
  input wire lock_detect, // lock
  input wire relock_request // relock pulse
);
  reg rd_ph_r;
  reg wr_ldc_r;
  reg used_r;
  reg vco_r;
  reg src_r;
  reg [3:0] since_r;
  wire take = hsel & htrans[1] & hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_r <= 1'b0;
      wr_ldc_r <= 1'b0;
      used_r <= 1'b0;
      vco_r <= 1'b0;
      src_r <= 1'b0;
      since_r <= 4'hF;
    end else begin
      rd_ph_r <= take & !hwrite;
      wr_ldc_r <= take & hwrite & (haddr == 8'h1C);
      // any config write re-arms the single attempt
      used_r <= wr_ldc_r ? 1'b0 : (used_r | relock_request);
      vco_r <= vco_div_in;
      src_r <= pin_function_gpo ? gpo_data : serial_readback_data;
      since_r <= (vco_div_in & !vco_r) ? 4'h0 : (since_r == 4'hF ? since_r : since_r + 4'h1);
    end
  end
  chk_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !rd_ph_r |-> $stable(hrdata)) else $error("read data moved without a read");
  chk_drv_gates_pad: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_readback_driver |-> lock_serial_out_pin_oe) else $error("driver on, pad off");
  chk_drv_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_readback_driver |-> $past(serial_addr_match) && !$past(pin_function_gpo))
    else $error("driver on without matching address");
  chk_pad_owner: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_serial_out_pin_oe && !serial_readback_driver |-> $past(pin_function_gpo))
    else $error("pad driven outside gpo mode");
  chk_pad_data: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_serial_out_pin_oe |-> lock_serial_out_pin_o == src_r) else $error("pad value wrong");
  chk_relock_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    relock_request |-> !lock_detect && $past(lock_detect)) else $error("relock without loss");
  chk_relock_once: assert property (@(posedge hclk) disable iff (!hresetn)
    relock_request |-> !used_r) else $error("second relock attempt");
  chk_lock_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(lock_detect) |-> since_r <= 4'h7) else $error("lock without oscillator edge");
endmodule // pld_lock_enables_monitor

bind pld_lock_enables pld_lock_enables_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .vco_div_in, .pin_function_gpo, .serial_addr_match,
  .serial_readback_data, .gpo_data, .lock_serial_out_pin_o, .lock_serial_out_pin_oe,
  .serial_readback_driver, .lock_detect, .relock_request);

// File: dv/pld_pll_model.sv
`timescale 1ns/1ps
module pld_pll_model (
  input wire hclk, // system clock
  input wire run, // produce edges
  input wire [3:0] lag, // oscillator lag in cycles
  output reg ref_edge_in = 1'b0, // reference clock
  output reg vco_div_in = 1'b0 // divided oscillator
);
  reg [3:0] ph_r = 4'h0;
  // both clocks stand low while stopped; phases of 8 cycles
  always @(posedge hclk) begin
    ph_r <= run ? ph_r + 4'h1 : 4'h0;
    ref_edge_in <= run && ph_r < 4'h8;
    vco_div_in <= run && 4'(ph_r - lag) < 4'h8;
  end
endmodule // pld_pll_model
